// ---- logic/sys_err_pkg.sv ----
// shared constants for the system error escalation block
package sys_err_pkg;
  // sticky flag positions in the status vector
  localparam int FLG_PCI_SERR = 0;
  localparam int FLG_PCI_PERR = 1;
  localparam int FLG_FSB_PAR = 2;
  localparam int FLG_MEM_CE = 3;
  localparam int FLG_MEM_UE = 4;
  localparam int FLG_FSB_PROTO = 5;
  localparam int FLG_LINK_PAR = 6;
  localparam int FLG_LINK_PROTO = 7;
  localparam int FLG_W = 8;
  // class enable positions
  localparam int EN_PCI = 0;
  localparam int EN_FSB = 1;
  localparam int EN_MEM = 2;
  localparam int EN_LINK = 3;
  localparam int EN_W = 4;
  // error report mask fields
  localparam int MASK_CE = 0;
  localparam int MASK_FATAL = 1;
  localparam int MASK_W = 2;
  // reset values
  localparam logic [FLG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic SERR_NMI_EN_RST = 1'b1;
  localparam logic [MASK_W-1:0] MASK_RST = 2'h3;
  // acknowledge wait in cycles before a request counts as unanswered
  localparam int ACK_WAIT = 16;
  localparam int ACK_CNT_W = 5;
  typedef enum logic [1:0] {LNK_IDLE, LNK_WAIT, LNK_RETRY} link_state_t;
endpackage

// ---- logic/system_error_escalation.sv ----
// system error collection and escalation to nmi, smi and fatal outputs
`timescale 1ns/1ps
module system_error_escalation
  import sys_err_pkg::*;
#(
  parameter int DATA_W = 64, // processor bus data width
  parameter int LINK_W = 16 // interconnect bus word width
) (
  input wire logic clk_sys, // 20 mhz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic global_en, // group enable for all classes
  input wire logic [sys_err_pkg::EN_W-1:0] class_en, // per class enables
  input wire logic serr_nmi_en_wr, // pulse: load nmi routing enable
  input wire logic serr_nmi_en_val, // value for nmi routing enable
  input wire logic [sys_err_pkg::MASK_W-1:0] mask_wr_val, // error_report_mask value
  input wire logic mask_wr, // pulse: load error_report_mask
  input wire logic [sys_err_pkg::FLG_W-1:0] flag_clr, // write one to clear flags
  input wire logic pci_perr_n, // pci parity error pin
  input wire logic pci_serr_n, // pci system error pin
  input wire logic fsb_valid, // processor bus phase valid
  input wire logic [DATA_W-1:0] fsb_addr_req, // address/request bits
  input wire logic fsb_par, // parity sent with phase
  input wire logic fsb_proto_err, // bus protocol violation seen
  input wire logic [DATA_W-1:0] fsb_wdata, // data to drive onto processor bus
  input wire logic fsb_wvalid, // drive data this cycle
  input wire logic mem_ce, // correctable memory ecc event
  input wire logic mem_ue, // uncorrectable memory ecc event
  input wire logic rx_valid, // link receive word valid
  input wire logic [LINK_W-1:0] rx_data, // link receive word
  input wire logic rx_par, // link receive parity
  input wire logic tx_req, // user request to send on link
  input wire logic [LINK_W-1:0] tx_req_data, // user request word
  input wire logic link_ack, // link acknowledge from far end
  input wire logic link_ack_err, // acknowledge reports error
  output logic nmi, // nmi request
  output logic smi, // smi request
  output logic alert_n, // correctable error output, active low
  output logic fatal_n, // fatal error output, active low
  output logic halt, // system halt request
  output logic log_req, // pulse: ask management controller to log
  output logic log_dimm_valid, // log entry carries failing dimm location
  output logic [sys_err_pkg::FLG_W-1:0] flags, // sticky status
  output logic serr_nmi_en, // current nmi routing enable
  output logic [sys_err_pkg::MASK_W-1:0] error_report_mask, // current mask
  output logic [DATA_W-1:0] fsb_data_out, // driven data
  output logic [7:0] fsb_ecc_out, // driven check bits
  output logic fsb_data_oe, // processor bus data enable
  output logic tx_valid, // link transmit valid
  output logic [LINK_W-1:0] tx_data, // link transmit word
  output logic tx_par, // link transmit parity
  output logic tx_busy // link requester not ready
);
  import sys_err_pkg::*;

  // simple check-bit code: parity over interleaved slices of the data
  function automatic logic [7:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < DATA_W; i++) begin
      e[i % 8] = e[i % 8] ^ d[i];
    end
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin synchronisers for asynchronous error pins
  logic [1:0] perr_sync;
  logic [1:0] serr_sync;
  logic [1:0] ce_sync;
  logic [1:0] ue_sync;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      perr_sync <= 2'h3;
      serr_sync <= 2'h3;
      ce_sync <= 2'h0;
      ue_sync <= 2'h0;
    end else begin
      perr_sync <= {perr_sync[0], pci_perr_n};
      serr_sync <= {serr_sync[0], pci_serr_n};
      ce_sync <= {ce_sync[0], mem_ce};
      ue_sync <= {ue_sync[0], mem_ue};
    end
  end

  ////////////////////////////////////////////////////////////////
  // class enables and event detection
  // class and group gating
  wire en_pci = global_en & class_en[EN_PCI];
  wire en_fsb = global_en & class_en[EN_FSB];
  wire en_mem = global_en & class_en[EN_MEM];
  wire en_link = global_en & class_en[EN_LINK];
  // pci system error line carries all non-parity pci errors
  wire ev_pci_serr = en_pci & ~serr_sync[1];
  // parity pin only logged; the master escalates via serr if it chooses
  wire ev_pci_perr = en_pci & ~perr_sync[1];
  wire ev_fsb_par = en_fsb & fsb_valid & ((^fsb_addr_req) != fsb_par);
  wire ev_fsb_proto = en_fsb & fsb_proto_err;
  wire ev_ce = en_mem & ce_sync[1];
  wire ev_ue = en_mem & ue_sync[1];
  // receive parity checked on every link word
  wire ev_link_par = en_link & rx_valid & ((^rx_data) != rx_par);
  logic ev_link_proto;
  wire [FLG_W-1:0] events = {ev_link_proto, ev_link_par, ev_fsb_proto, ev_ue,
                             ev_ce, ev_fsb_par, ev_pci_perr, ev_pci_serr};

  ////////////////////////////////////////////////////////////////
  // sticky flags; a new event beats a clear in the same cycle
  // sticky hold until cleared
  wire [FLG_W-1:0] next_flags = (flags & ~flag_clr) | events;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration: routing enable and error report mask
  // routing enable comes up set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serr_nmi_en <= SERR_NMI_EN_RST;
      error_report_mask <= MASK_RST;
    end else begin
      if (serr_nmi_en_wr) begin
        serr_nmi_en <= serr_nmi_en_val;
      end
      if (mask_wr) begin
        error_report_mask <= mask_wr_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // escalation outputs, all registered; nmi, smi, alert, fatal and halt from the sticky flags, log outputs from the events
  // serr to nmi
  wire next_nmi = flags[FLG_PCI_SERR] & serr_nmi_en;
  wire next_alert = flags[FLG_MEM_CE] & error_report_mask[MASK_CE];
  wire fatal_src = flags[FLG_MEM_UE] | flags[FLG_FSB_PROTO] | flags[FLG_FSB_PAR] |
                   flags[FLG_LINK_PAR] | flags[FLG_LINK_PROTO];
  // fatal gated by its own mask bit
  wire next_fatal = fatal_src & error_report_mask[MASK_FATAL];
  // correctable ecc raises smi without halting
  wire next_smi = flags[FLG_MEM_CE];
  // uncorrectable ecc halts; halt is held until reset, a fatal stop
  wire next_halt = halt | flags[FLG_MEM_UE];
  wire log_ev = ev_ce | ev_ue;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmi <= 1'b0;
      smi <= 1'b0;
      alert_n <= 1'b1;
      fatal_n <= 1'b1;
      halt <= 1'b0;
      log_req <= 1'b0;
      log_dimm_valid <= 1'b0;
    end else begin
      nmi <= next_nmi;
      smi <= next_smi;
      alert_n <= ~next_alert;
      fatal_n <= ~next_fatal;
      halt <= next_halt;
      // log request; dimm location only for correctable events
      log_req <= log_ev;
      log_dimm_valid <= ev_ce & ~ev_ue;
    end
  end

  ////////////////////////////////////////////////////////////////
  // processor bus data drive with check bits
  // ecc always generated with driven data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fsb_data_out <= '0;
      fsb_ecc_out <= 8'h00;
      fsb_data_oe <= 1'b0;
    end else begin
      fsb_data_oe <= fsb_wvalid;
      if (fsb_wvalid) begin
        fsb_data_out <= fsb_wdata;
        fsb_ecc_out <= ecc_gen(fsb_wdata);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interconnect requester: send, await ack, retry on error or timeout
  link_state_t lstate;
  link_state_t next_lstate;
  logic [ACK_CNT_W-1:0] ack_cnt;
  wire ack_timeout = (ack_cnt == ACK_CNT_W'(ACK_WAIT - 1));
  wire ack_bad = (lstate == LNK_WAIT) & ((link_ack & link_ack_err) | (~link_ack & ack_timeout));
  assign tx_busy = (lstate != LNK_IDLE);
  // bad or missing ack is reported
  assign ev_link_proto = en_link & ack_bad;
  always_comb begin
    next_lstate = lstate;
    case (lstate)
      LNK_IDLE: begin
        if (tx_req) begin
          next_lstate = LNK_WAIT;
        end
      end
      LNK_WAIT: begin
        if (ack_bad) begin
          next_lstate = LNK_RETRY;
        end else if (link_ack) begin
          next_lstate = LNK_IDLE;
        end
      end
      LNK_RETRY: next_lstate = LNK_WAIT;
      default: next_lstate = LNK_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lstate <= LNK_IDLE;
      ack_cnt <= '0;
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_par <= 1'b0;
    end else begin
      lstate <= next_lstate;
      ack_cnt <= (next_lstate == LNK_WAIT && lstate == LNK_WAIT) ? ack_cnt + 1'b1 : '0;
      tx_valid <= (lstate == LNK_IDLE && tx_req) || lstate == LNK_RETRY;
      if (lstate == LNK_IDLE && tx_req) begin
        tx_data <= tx_req_data;
        tx_par <= ^tx_req_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks on the escalation paths
  AST_NMI_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flags[FLG_PCI_SERR] && serr_nmi_en |=> nmi)
    else $error("nmi not raised for routed system error");
  AST_NMI_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !serr_nmi_en |=> !nmi)
    else $error("nmi raised with routing disabled");
  AST_ALERT_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !error_report_mask[MASK_CE] |=> alert_n)
    else $error("alert asserted while masked");
  AST_ALERT_CE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_ce && error_report_mask[MASK_CE] && !mask_wr |=> ##1 !alert_n)
    else $error("alert missing after correctable error");
  AST_FATAL_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !error_report_mask[MASK_FATAL] |=> fatal_n)
    else $error("fatal asserted while masked");
  AST_FATAL_UE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_ue && error_report_mask[MASK_FATAL] && !mask_wr |=> ##1 !fatal_n)
    else $error("fatal missing after uncorrectable error");
  AST_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flags[FLG_MEM_CE] && !flag_clr[FLG_MEM_CE] |=> flags[FLG_MEM_CE])
    else $error("sticky flag lost without clear");
  AST_HALT_UE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_ue |=> ##1 halt ##1 halt)
    else $error("halt not held after uncorrectable error");
  AST_ECC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsb_wvalid |=> fsb_data_oe && fsb_ecc_out == ecc_gen($past(fsb_wdata)))
    else $error("check bits wrong on driven data");
  AST_RETRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ack_bad |=> ##1 tx_valid)
    else $error("link request not retried");
  AST_FSB_PAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_fsb_par |=> flags[FLG_FSB_PAR])
    else $error("bus parity error not flagged");
  AST_HALT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt |=> halt)
    else $error("halt released before reset");
  AST_SMI_CE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_ce |=> ##1 smi)
    else $error("smi missing after correctable error");
  COV_NMI: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_pci_serr ##[1:4] nmi);
  COV_CE: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_ce ##[1:4] smi);
  COV_UE: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_ue ##[1:4] halt);
  COV_RETRY: cover property (@(posedge clk_sys) disable iff (!rst_n) lstate == LNK_RETRY);
  COV_LINK_FATAL: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_link_par ##[1:4] !fatal_n);
endmodule

// ---- verification/link_far_end.sv ----
// far end model of the interconnect link: acknowledges requests and checks their parity
`timescale 1ns/1ps
module link_far_end #(
  parameter int LINK_W = 16 // link word width
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [1:0] ack_mode, // 0 prompt, 1 slow, 2 error ack, 3 silent
  input wire logic tx_valid, // request word valid
  input wire logic [LINK_W-1:0] tx_data, // request word
  input wire logic tx_par, // request parity
  output logic link_ack, // acknowledge
  output logic link_ack_err, // acknowledge carries error
  output logic [7:0] par_bad // count of requests with bad parity
);
  logic pend;
  logic [3:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // the error qualifier churns while ack is low, so a design that reads it alone is caught
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend <= 1'b0;
      wait_cnt <= 4'h0;
      link_ack <= 1'b0;
      link_ack_err <= 1'b0;
      par_bad <= 8'h00;
    end else begin
      link_ack <= 1'b0;
      link_ack_err <= ~link_ack_err;
      if (tx_valid) begin
        pend <= 1'b1;
        wait_cnt <= (ack_mode == 2'd1) ? 4'hA : 4'h1;
        if (tx_par !== ^tx_data) begin
          par_bad <= par_bad + 8'h01;
        end
      end else if (pend && ack_mode != 2'd3) begin
        if (wait_cnt == 4'h1) begin
          link_ack <= 1'b1;
          link_ack_err <= (ack_mode == 2'd2);
          pend <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule

// ---- verification/system_error_escalation_tb_top.sv ----
// self-checking bench for the system error escalation block
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module system_error_escalation_tb_top;
  import sys_err_pkg::*;
  logic clk_sys, rst_n, global_en, serr_nmi_en_wr, serr_nmi_en_val, mask_wr, pci_perr_n, pci_serr_n;
  logic fsb_valid, fsb_par, fsb_proto_err, fsb_wvalid, mem_ce, mem_ue, rx_valid, rx_par, tx_req;
  logic link_ack, link_ack_err, nmi, smi, alert_n, fatal_n, halt, log_req, log_dimm_valid;
  logic serr_nmi_en, fsb_data_oe, tx_valid, tx_par, tx_busy, last_dimm, bad;
  logic [3:0] class_en, en;
  logic [1:0] mask_wr_val, error_report_mask, ack_mode;
  logic [7:0] flag_clr, flags, fsb_ecc_out, par_bad;
  logic [63:0] fsb_addr_req, fsb_wdata, fsb_data_out;
  logic [15:0] rx_data, tx_req_data, tx_data, last_tx;
  logic [31:0] seed = 32'h5A37;
  int num_errors = 0, num_checks = 0, n_log = 0, n_tx = 0, n0, k;
  system_error_escalation #(.DATA_W(64), .LINK_W(16)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .global_en(global_en),
    .class_en(class_en), .serr_nmi_en_wr(serr_nmi_en_wr), .serr_nmi_en_val(serr_nmi_en_val), .mask_wr(mask_wr),
    .mask_wr_val(mask_wr_val), .flag_clr(flag_clr), .pci_perr_n(pci_perr_n), .pci_serr_n(pci_serr_n),
    .fsb_valid(fsb_valid), .fsb_addr_req(fsb_addr_req), .fsb_par(fsb_par), .fsb_proto_err(fsb_proto_err),
    .fsb_wdata(fsb_wdata), .fsb_wvalid(fsb_wvalid), .mem_ce(mem_ce), .mem_ue(mem_ue), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_par(rx_par), .tx_req(tx_req), .tx_req_data(tx_req_data), .link_ack(link_ack),
    .link_ack_err(link_ack_err), .nmi(nmi), .smi(smi), .alert_n(alert_n), .fatal_n(fatal_n), .halt(halt),
    .log_req(log_req), .log_dimm_valid(log_dimm_valid), .flags(flags), .serr_nmi_en(serr_nmi_en),
    .error_report_mask(error_report_mask), .fsb_data_out(fsb_data_out), .fsb_ecc_out(fsb_ecc_out),
    .fsb_data_oe(fsb_data_oe), .tx_valid(tx_valid), .tx_data(tx_data), .tx_par(tx_par), .tx_busy(tx_busy));
  link_far_end #(.LINK_W(16)) far (.clk_sys(clk_sys), .rst_n(rst_n), .ack_mode(ack_mode), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_par(tx_par), .link_ack(link_ack), .link_ack_err(link_ack_err), .par_bad(par_bad));
  ////////////////////////////////////////////////////////////////////////////////
  // 20 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // log requests and link sends are pulses, so they are caught on every edge
  always @(posedge clk_sys) begin
    if (log_req === 1'b1) begin
      n_log++;
      last_dimm = log_dimm_valid;
    end
    if (tx_valid === 1'b1) begin
      n_tx++;
      last_tx = tx_data;
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ecc_of(input logic [63:0] d);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 64; i++) e[i % 8] ^= d[i];
    return e;
  endfunction
  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task clr();
    flag_clr = 8'hFF;
    tick(1);
    flag_clr = 8'h00;
    tick(1);
  endtask
  task reset_dut();
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    {rst_n, global_en, serr_nmi_en_wr, serr_nmi_en_val, mask_wr, fsb_valid, fsb_par, fsb_proto_err} = 8'h40;
    {fsb_wvalid, mem_ce, mem_ue, rx_valid, rx_par, tx_req, pci_perr_n, pci_serr_n} = 8'h03;
    {class_en, mask_wr_val, flag_clr, ack_mode} = 16'hF000;
    {fsb_addr_req, fsb_wdata, rx_data, tx_req_data} = '0;
    reset_dut();
    `CHK({nmi, smi, alert_n, fatal_n, halt, flags, serr_nmi_en, error_report_mask}, 16'h3007)
    $display("reset values done");
    for (int i = 0; i < 2; i++) begin
      serr_nmi_en_val = (i == 0);
      serr_nmi_en_wr = 1'b1;
      tick(1);
      serr_nmi_en_wr = 1'b0;
      pci_serr_n = 1'b0;
      tick(1);
      pci_serr_n = 1'b1;
      tick(6);
      `CHK(flags, 8'h01)
      `CHK(nmi, serr_nmi_en_val)
      `CHK(serr_nmi_en, serr_nmi_en_val)
      clr();
    end
    pci_perr_n = 1'b0;
    tick(1);
    pci_perr_n = 1'b1;
    tick(6);
    `CHK({nmi, flags}, 9'h002)
    clr();
    `CHK(flags, 8'h00)
    $display("pci errors done");
    for (int c = 0; c < 6; c++) begin
      global_en = (c != 4);
      class_en = (c < 4) ? ~(4'h1 << c) : 4'hF;
      en = global_en ? class_en : 4'h0;
      {pci_serr_n, fsb_valid, fsb_proto_err, mem_ce, rx_valid, rx_data, rx_par} = 22'h0F0003;
      tick(1);
      {pci_serr_n, fsb_valid, fsb_proto_err, mem_ce, rx_valid} = 5'h10;
      tick(6);
      `CHK(flags, {1'b0, en[3], en[1], 1'b0, en[2], 2'b00, en[0]})
      clr();
    end
    $display("class enables done");
    for (int i = 0; i < 8; i++) begin
      fsb_addr_req = {xs(), xs()};
      bad = ^(xs() & 32'h1);
      fsb_par = ^fsb_addr_req ^ bad;
      fsb_valid = 1'b1;
      fsb_wdata = {xs(), xs()};
      fsb_wvalid = 1'b1;
      tick(1);
      {fsb_valid, fsb_wvalid} = 2'b00;
      `CHK({fsb_data_oe, fsb_data_out, fsb_ecc_out}, {1'b1, fsb_wdata, ecc_of(fsb_wdata)})
      tick(5);
      `CHK({flags[2], fatal_n}, {bad, ~bad})
      clr();
    end
    $display("processor bus done");
    for (int m = 0; m < 2; m++) begin
      mask_wr_val = {1'b1, m[0]};
      mask_wr = 1'b1;
      tick(1);
      mask_wr = 1'b0;
      n0 = n_log;
      mem_ce = 1'b1;
      tick(1);
      mem_ce = 1'b0;
      tick(6);
      `CHK({flags, smi, halt}, 10'h022)
      `CHK(alert_n, ~m[0])
      `CHK(error_report_mask, mask_wr_val)
      `CHK({n_log - n0, last_dimm}, {32'd1, 1'b1})
      clr();
      `CHK({smi, alert_n, flags}, 10'h100)
    end
    mask_wr_val = 2'b01;
    mask_wr = 1'b1;
    tick(1);
    mask_wr = 1'b0;
    fsb_proto_err = 1'b1;
    tick(1);
    fsb_proto_err = 1'b0;
    tick(6);
    `CHK({flags, fatal_n}, 9'h041)
    clr();
    mask_wr_val = 2'b11;
    mask_wr = 1'b1;
    tick(1);
    mask_wr = 1'b0;
    $display("memory and mask done");
    for (int b = 0; b < 2; b++) begin
      rx_data = 16'(xs());
      rx_par = ^rx_data ^ b[0];
      rx_valid = 1'b1;
      tick(1);
      rx_valid = 1'b0;
      tick(6);
      `CHK({flags, fatal_n}, {1'b0, b[0], 6'h00, ~b[0]})
      clr();
    end
    for (int m = 0; m < 4; m++) begin
      ack_mode = 2'(m);
      n0 = n_tx;
      tx_req_data = 16'(xs());
      tx_req = 1'b1;
      tick(1);
      tx_req = 1'b0;
      tick(40);
      `CHK({flags[7], n_tx - n0 > 1, last_tx}, {m[1], m[1], tx_req_data})
      ack_mode = 2'd0;
      for (k = 0; k < 60 && tx_busy !== 1'b0; k++) tick(1);
      `CHK(tx_busy, 1'b0)
      clr();
    end
    `CHK(par_bad, 8'h00)
    $display("link done");
    n0 = n_log;
    mem_ue = 1'b1;
    tick(1);
    mem_ue = 1'b0;
    tick(6);
    `CHK({flags, fatal_n, halt}, 10'h041)
    `CHK({n_log - n0, last_dimm}, {32'd1, 1'b0})
    clr();
    tick(3);
    `CHK(halt, 1'b1)
    reset_dut();
    `CHK(halt, 1'b0)
    $display("fatal memory done");
    end_of_test();
  end
endmodule
